/* sim/srf_printer_model.sv */
`timescale 1ns/10ps
module srf_printer_model
    import srf_pkg::*;
#(
    parameter int BASE_DIV = 128
) (
    input wire logic clk,
    input wire logic line,
    input wire logic [3:0] framing
);
    logic [7:0] rx_q[$];
    int rx_t[$];
    int frame_err = 0;
    int cyc = 0;
    int div;
    int par;
    logic [7:0] sh;
    always @(posedge clk) cyc <= cyc + 1;
    always begin
        @(negedge line);
        div = BASE_DIV >> (framing / 3);
        par = framing % 3;
        repeat (div / 2) @(posedge clk);
        if (line !== 1'b0) frame_err++;
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk);
            sh[i] = line;
        end
        if (par != 0 && (^sh) !== (par == 1)) frame_err++;
        if (par != 0) sh[7] = 1'b0;
        repeat (div) @(posedge clk);
        if (line !== 1'b1) frame_err++;
        rx_q.push_back(sh);
        rx_t.push_back(cyc);
    end
endmodule

/* sim/srf_report_formatter_sva.sv */
`timescale 1ns/10ps
module srf_report_formatter_sva
    import srf_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_fitted,
    input wire logic cfg_we,
    input wire logic [FRAMING_W-1:0] cfg_line_framing_select,
    input wire logic [ADDR_W-1:0] cfg_unit_address_setting,
    input wire logic [1:0] cfg_print_content_select,
    input wire logic factory_restore,
    input wire logic xmit_req,
    input wire logic [1:0] xmit_sel,
    input wire logic [FRAMING_W-1:0] line_framing_select,
    input wire logic [ADDR_W-1:0] unit_address_setting,
    input wire logic short_report_select,
    input wire logic [1:0] print_content_select,
    input wire logic reset_after_print_select,
    input wire logic cfg_reject,
    input wire logic req_ack,
    input wire logic timer_reset,
    input wire logic busy,
    input wire logic tx_line,
    input wire logic tx_drive_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int hold_cnt;
    wire fields_ok = cfg_line_framing_select < FRAMING_COUNT &&
        cfg_unit_address_setting <= ADDR_MAX &&
        cfg_print_content_select != CONTENT_NONE;
    wire cfg_try = cfg_we && serial_fitted && !factory_restore;
    // cycles since the last accepted request
    always_ff @(posedge clk) begin
        if (!rst_n)
            hold_cnt <= 0;
        else if (req_ack)
            hold_cnt <= 1;
        else if (busy && hold_cnt < HOLD_CYCLES + 8)
            hold_cnt <= hold_cnt + 1;
    end
    ack_req_a: assert property (
        xmit_req && xmit_sel != 2'h3 && !busy && serial_fitted |=> req_ack)
        else $error("transmit request not acknowledged");
    hold_quiet_a: assert property (
        req_ack |-> busy && !tx_drive_en)
        else $error("line driven at request acknowledge");
    hold_time_a: assert property (
        $rose(tx_drive_en) |-> hold_cnt >= HOLD_CYCLES - 1)
        else $error("report started before the hold time");
    idle_mark_a: assert property (
        !tx_drive_en |-> tx_line)
        else $error("line not at mark while idle");
    unfitted_quiet_a: assert property (
        !serial_fitted |-> !req_ack && !tx_drive_en && !busy)
        else $error("serial activity without the option");
    cfg_take_a: assert property (
        cfg_try && fields_ok |=>
        line_framing_select == $past(cfg_line_framing_select) &&
        unit_address_setting == $past(cfg_unit_address_setting))
        else $error("valid setting write not taken");
    cfg_keep_a: assert property (
        cfg_try && !fields_ok |=> $stable(line_framing_select) &&
        $stable(unit_address_setting) && $stable(print_content_select))
        else $error("refused write changed a setting");
    reject_flag_a: assert property (
        cfg_try && !fields_ok |-> ##[1:2] cfg_reject)
        else $error("refused write not flagged");
    restore_def_a: assert property (
        factory_restore && serial_fitted |=>
        line_framing_select == RATE_9600_NO_PARITY_CODE &&
        unit_address_setting == ADDR_DEFAULT && !short_report_select &&
        print_content_select == CONTENT_BOTH && !reset_after_print_select)
        else $error("restore did not give defaults");
    addr_range_a: assert property (
        unit_address_setting <= ADDR_MAX)
        else $error("unit address above range");
    timer_clear_a: assert property (
        timer_reset |-> req_ack && reset_after_print_select &&
        print_content_select[0])
        else $error("timer reset without cause");
    cover property (req_ack && timer_reset);
    cover property (cfg_reject);
    cover property ($rose(tx_drive_en));
endmodule

bind srf_report_formatter srf_report_formatter_sva
    #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.*);

/* sim/srf_report_formatter_test.sv */
`timescale 1ns/10ps
module srf_report_formatter_test
    import srf_pkg::*;
;
    localparam int BASE = 128;
    localparam int GAP = 2000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic serial_fitted = 1'b1;
    logic cfg_we = 1'b0;
    logic [3:0] cfg_line_framing_select = 4'h0;
    logic [6:0] cfg_unit_address_setting = 7'h00;
    logic cfg_short_report_select = 1'b0;
    logic [1:0] cfg_print_content_select = 2'h0;
    logic cfg_reset_after_print_select = 1'b0;
    logic factory_restore = 1'b0;
    logic xmit_req = 1'b0;
    logic print_req = 1'b0;
    logic print_input = 1'b0;
    logic [1:0] xmit_sel = 2'h0;
    logic [23:0] timer_value = 24'h000507;
    logic [23:0] preset1_value = 24'h120000;
    logic [23:0] preset2_value = 24'h000000;
    logic [3:0] line_framing_select;
    logic [6:0] unit_address_setting;
    logic [1:0] print_content_select;
    logic short_report_select, reset_after_print_select, cfg_reject;
    logic req_ack, timer_reset, busy, tx_line, tx_drive_en;
    logic acked, rst_seen, rej;
    int error_cnt = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    srf_report_formatter #(.HOLD_CYCLES(10), .GAP_CYCLES(GAP),
        .BAUD_DIV_1200(BASE)) dut (.*);
    srf_printer_model #(.BASE_DIV(BASE)) peer (.clk(clk), .line(tx_line),
        .framing(line_framing_select));
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk_val(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic do_reset(input logic fit);
        @(posedge clk);
        rst_n <= 1'b0;
        serial_fitted <= fit;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask
    // fields: framing, address, short, content, reset after print
    task automatic cfg(input logic [14:0] v, input logic restore);
        rej = 1'b0;
        @(posedge clk);
        cfg_we <= !restore;
        factory_restore <= restore;
        {cfg_line_framing_select, cfg_unit_address_setting,
            cfg_short_report_select, cfg_print_content_select,
            cfg_reset_after_print_select} <= v;
        @(posedge clk);
        cfg_we <= 1'b0;
        factory_restore <= 1'b0;
        repeat (2) begin
            @(negedge clk);
            rej = rej | (cfg_reject === 1'b1);
        end
    endtask
    task automatic chk_cfg(input logic [14:0] v);
        chk_val("settings", 32'(v), 32'({line_framing_select,
            unit_address_setting, short_report_select,
            print_content_select, reset_after_print_select}));
    endtask
    // kind 0 transmit, 1 print command, 2 print input
    task automatic req(input int kind, input logic [1:0] sel);
        acked = 1'b0;
        rst_seen = 1'b0;
        @(posedge clk);
        xmit_sel <= sel;
        xmit_req <= (kind == 0);
        print_req <= (kind == 1);
        print_input <= (kind == 2);
        @(posedge clk);
        xmit_req <= 1'b0;
        print_req <= 1'b0;
        for (int i = 0; i < 8 && !acked; i++) begin
            @(negedge clk);
            acked = (req_ack === 1'b1);
            rst_seen = (timer_reset === 1'b1);
        end
        @(posedge clk);
        print_input <= 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200000) begin
            chk_val("busy", 0, busy);
            print_verdict();
        end
    endtask
    task automatic chk_gap(input int at, input int lo, input int hi);
        int d;
        d = peer.rx_t[at] - peer.rx_t[at - 1];
        chk_val("char spacing in range", 1, 32'(d >= lo && d <= hi));
    endtask
    task automatic expect_rx(input string exp);
        chk_val("char count", exp.len(), peer.rx_q.size());
        for (int i = 0; i < exp.len() && i < peer.rx_q.size(); i++)
            chk_val("char", exp[i], peer.rx_q[i]);
        chk_val("frame errors", 0, peer.frame_err);
        peer.rx_q.delete();
        peer.rx_t.delete();
    endtask
    function automatic string fmt(input int sel, input int ad, input logic sh);
        string mn[3] = '{"TMR", "P1 ", "P2 "};
        string s;
        logic [23:0] v;
        int lead;
        v = sel == 0 ? timer_value : sel == 1 ? preset1_value : preset2_value;
        s = sh ? "" : $sformatf("%0d%0d %s ", ad / 10, ad % 10, mn[sel]);
        lead = 1;
        for (int i = 5; i >= 0; i--) begin
            if (v[i*4 +: 4] != 4'h0 || i == 0) lead = 0;
            if (!lead) s = {s, $sformatf("%0d", v[i*4 +: 4])};
            else if (!sh) s = {s, " "};
        end
        return {s, "\r\n"};
    endfunction
    initial begin
        do_reset(1'b1);
        chk_cfg({4'h9, 7'h00, 1'b0, 2'h3, 1'b0});
        for (int s = 0; s < 3; s++) begin
            req(0, 2'(s));
            chk_val("ack", 1, acked);
            wait_done();
            expect_rx(fmt(s, 0, 1'b0));
        end
        req(0, 2'h3);
        chk_val("ack", 0, acked);
        cfg({4'h7, 7'h63, 1'b0, 2'h1, 1'b1}, 1'b0);
        chk_cfg({4'h7, 7'h63, 1'b0, 2'h1, 1'b1});
        req(1, 2'h0);
        chk_val("timer reset", 1, rst_seen);
        wait_done();
        expect_rx(fmt(0, 99, 1'b0));
        cfg({4'hc, 7'h01, 1'b0, 2'h1, 1'b1}, 1'b0);
        chk_val("reject", 1, rej);
        cfg({4'h3, 7'h64, 1'b0, 2'h1, 1'b1}, 1'b0);
        chk_val("reject", 1, rej);
        chk_cfg({4'h7, 7'h63, 1'b0, 2'h1, 1'b1});
        cfg({4'h2, 7'h05, 1'b1, 2'h2, 1'b1}, 1'b0);
        req(1, 2'h0);
        chk_val("timer reset", 0, rst_seen);
        wait_done();
        chk_gap(8, 1270, 1300);
        expect_rx({fmt(1, 5, 1'b1), fmt(2, 5, 1'b1)});
        cfg(15'h0000, 1'b1);
        chk_cfg({4'h9, 7'h00, 1'b0, 2'h3, 1'b0});
        req(2, 2'h0);
        chk_val("ack", 1, acked);
        chk_val("timer reset", 0, rst_seen);
        wait_done();
        chk_gap(15, 160 + GAP, 210 + GAP);
        chk_gap(30, 160 + GAP, 210 + GAP);
        expect_rx({fmt(0, 0, 0), fmt(1, 0, 0), fmt(2, 0, 0)});
        do_reset(1'b0);
        cfg({4'h3, 7'h01, 1'b0, 2'h1, 1'b0}, 1'b0);
        chk_val("reject", 1, rej);
        req(0, 2'h0);
        chk_val("ack", 0, acked);
        print_verdict();
    end
endmodule

/* src/srf_fifo.sv */
`timescale 1ns/10ps
module srf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_valid,
    input wire logic [WIDTH-1:0] s_data,
    output logic s_ready,
    output logic m_valid,
    output logic [WIDTH-1:0] m_data,
    input wire logic m_ready
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("srf_fifo: depth below 2 or width below 1");
        end
    endgenerate

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_r;
    logic [PTR_W-1:0] rd_r;
    logic [CNT_W-1:0] cnt_r;
    wire push = s_valid && s_ready;
    wire pop = m_valid && m_ready;

    assign s_ready = (cnt_r != CNT_W'(DEPTH));
    assign m_valid = (cnt_r != '0);
    assign m_data = mem_r[rd_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= s_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= ptr_inc(wr_r);
            if (pop) rd_r <= ptr_inc(rd_r);
            if (push && !pop) cnt_r <= cnt_r + 1'b1;
            else if (pop && !push) cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

/* src/srf_pkg.sv */
package srf_pkg;

    // clock and timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int HOLD_MS = 100;
    localparam int PRINTER_DELAY_MS = 400;
    localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int GAP_CYC = PRINTER_DELAY_MS * CYC_PER_MS;
    localparam int SLOWEST_BAUD = 1200;
    localparam int BAUD_DIV_SLOW = CLK_HZ / SLOWEST_BAUD;
    localparam int MIN_BAUD_DIV = 16;

    // line framing selector: code = rate * 3 + parity kind
    localparam int FRAMING_W = 4;
    localparam logic [3:0] FRAMING_COUNT = 4'hc;
    localparam logic [3:0] RATE_9600_NO_PARITY_CODE = 4'h9;
    localparam logic [3:0] PARITY_KINDS = 4'h3;
    localparam int RATE_W = 2;
    localparam int FRAME_BITS = 10;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ODD = 2'h1,
        PAR_EVEN = 2'h2
    } srf_parity_t;

    // unit address
    localparam int ADDR_W = 7;
    localparam logic [6:0] ADDR_MAX = 7'h63;
    localparam logic [6:0] ADDR_DEFAULT = 7'h00;
    localparam logic [6:0] ADDR_RADIX = 7'h0a;

    // print content codes
    localparam logic [1:0] CONTENT_NONE = 2'h0;
    localparam logic [1:0] CONTENT_TIMER = 2'h1;
    localparam logic [1:0] CONTENT_PRESETS = 2'h2;
    localparam logic [1:0] CONTENT_BOTH = 2'h3;
    localparam logic [1:0] CONTENT_DEFAULT = CONTENT_BOTH;
    localparam logic SHORT_DEFAULT = 1'b0;
    localparam logic RAP_DEFAULT = 1'b0;

    // values: bcd digits, most significant first
    localparam int DIGITS = 6;
    localparam int VAL_W = DIGITS * 4;
    localparam logic [1:0] VAL_TIMER = 2'h0;
    localparam logic [1:0] VAL_P1 = 2'h1;
    localparam logic [1:0] VAL_P2 = 2'h2;
    localparam logic [2:0] MASK_NONE = 3'h0;

    // report character positions
    localparam logic [3:0] POS_ADDR_HI = 4'h0;
    localparam logic [3:0] POS_ADDR_LO = 4'h1;
    localparam logic [3:0] POS_MN0 = 4'h3;
    localparam logic [3:0] POS_MN1 = 4'h4;
    localparam logic [3:0] POS_MN2 = 4'h5;
    localparam logic [3:0] POS_DIG0 = 4'h7;
    localparam logic [3:0] POS_CR = 4'hd;
    localparam logic [3:0] POS_LF = 4'he;

    // characters
    localparam int CHAR_W = 8;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_TWO = 8'h32;
    localparam logic [7:0] CH_M = 8'h4d;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_T = 8'h54;

    localparam int FIFO_DEPTH = 4;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_HOLD = 5'h02,
        ST_EMIT = 5'h04,
        ST_DRAIN = 5'h08,
        ST_GAP = 5'h10
    } srf_state_t;

endpackage

/* src/srf_report_formatter.sv */
`timescale 1ns/10ps
module srf_report_formatter
    import srf_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int GAP_CYCLES = GAP_CYC,
    parameter int BAUD_DIV_1200 = BAUD_DIV_SLOW,
    parameter int QUEUE_DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic serial_fitted,
    input wire logic cfg_we,
    input wire logic [FRAMING_W-1:0] cfg_line_framing_select,
    input wire logic [ADDR_W-1:0] cfg_unit_address_setting,
    input wire logic cfg_short_report_select,
    input wire logic [1:0] cfg_print_content_select,
    input wire logic cfg_reset_after_print_select,
    input wire logic factory_restore,
    input wire logic xmit_req,
    input wire logic [1:0] xmit_sel,
    input wire logic print_req,
    input wire logic print_input,
    input wire logic [VAL_W-1:0] timer_value,
    input wire logic [VAL_W-1:0] preset1_value,
    input wire logic [VAL_W-1:0] preset2_value,
    output logic [FRAMING_W-1:0] line_framing_select,
    output logic [ADDR_W-1:0] unit_address_setting,
    output logic short_report_select,
    output logic [1:0] print_content_select,
    output logic reset_after_print_select,
    output logic cfg_reject,
    output logic req_ack,
    output logic timer_reset,
    output logic busy,
    output logic tx_line,
    output logic tx_drive_en
);
    localparam int LONGEST = (HOLD_CYCLES > GAP_CYCLES) ?
        HOLD_CYCLES : GAP_CYCLES;
    localparam int CNT_W = $clog2(LONGEST + 1);
    localparam int DIV_W = $clog2(BAUD_DIV_1200 + 1);

    generate
        if (HOLD_CYCLES < 1 || GAP_CYCLES < 1 ||
            BAUD_DIV_1200 < MIN_BAUD_DIV || QUEUE_DEPTH < 2) begin : g_bad
            $error("srf_report_formatter: parameter out of range");
        end
    endgenerate

    // index of first nonzero digit, last digit if all zero
    function automatic logic [2:0] first_sig(input logic [VAL_W-1:0] v);
        logic [2:0] r;
        r = 3'(DIGITS - 1);
        for (int k = DIGITS - 1; k >= 0; k--) begin
            if (v[(DIGITS-1-k)*4 +: 4] != 4'h0) r = 3'(k);
        end
        return r;
    endfunction

    function automatic logic [7:0] char_at(
        input logic [3:0] idx,
        input logic [VAL_W-1:0] v,
        input logic [ADDR_W-1:0] addr,
        input logic [1:0] sel
    );
        logic [7:0] c;
        logic [2:0] k;
        logic [3:0] d;
        c = CH_SP;
        k = 3'(idx - POS_DIG0);
        d = v[(DIGITS-1-int'(k))*4 +: 4];
        case (idx)
            POS_ADDR_HI: c = CH_ZERO + 8'(addr / ADDR_RADIX);
            POS_ADDR_LO: c = CH_ZERO + 8'(addr % ADDR_RADIX);
            POS_MN0: c = (sel == VAL_TIMER) ? CH_T : CH_P;
            POS_MN1: c = (sel == VAL_TIMER) ? CH_M :
                         ((sel == VAL_P1) ? CH_ONE : CH_TWO);
            POS_MN2: c = (sel == VAL_TIMER) ? CH_R : CH_SP;
            POS_CR: c = CH_CR;
            POS_LF: c = CH_LF;
            default: begin
                // leading zeros blanked: right-justified digits
                if (idx >= POS_DIG0 && idx < POS_CR) begin
                    c = (k < first_sig(v)) ? CH_SP : CH_ZERO + {4'h0, d};
                end
            end
        endcase
        return c;
    endfunction

    function automatic logic [1:0] first_sel(input logic [2:0] m);
        return m[0] ? VAL_TIMER : (m[1] ? VAL_P1 : VAL_P2);
    endfunction

    // option strap, caught at reset
    logic fitted_r;
    always_ff @(posedge clk) begin
        if (!rst_n) fitted_r <= serial_fitted;
    end

    // print input pin: three flops, change taken when last two agree
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic print_lvl_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            print_lvl_r <= 1'b0;
        end else begin
            pin_s1_r <= print_input;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) print_lvl_r <= pin_s3_r;
        end
    end

    // settings
    wire cfg_ok = (cfg_line_framing_select < FRAMING_COUNT) &&
                  (cfg_unit_address_setting <= ADDR_MAX) &&
                  (cfg_print_content_select != CONTENT_NONE);
    wire cfg_take = cfg_we && fitted_r && cfg_ok;

    always_ff @(posedge clk) begin
        if (!rst_n || (factory_restore && fitted_r)) begin
            line_framing_select <= RATE_9600_NO_PARITY_CODE;
            unit_address_setting <= ADDR_DEFAULT;
            short_report_select <= SHORT_DEFAULT;
            print_content_select <= CONTENT_DEFAULT;
            reset_after_print_select <= RAP_DEFAULT;
        end else if (cfg_take) begin
            line_framing_select <= cfg_line_framing_select;
            unit_address_setting <= cfg_unit_address_setting;
            short_report_select <= cfg_short_report_select;
            print_content_select <= cfg_print_content_select;
            reset_after_print_select <= cfg_reset_after_print_select;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) cfg_reject <= 1'b0;
        else cfg_reject <= cfg_we && !factory_restore && !cfg_take;
    end

    // framing decode: rate index and parity kind
    wire [RATE_W-1:0] rate_idx =
        RATE_W'(line_framing_select / PARITY_KINDS);
    wire srf_parity_t par_kind =
        srf_parity_t'(2'(line_framing_select % PARITY_KINDS));
    wire [DIV_W-1:0] bit_div = DIV_W'(BAUD_DIV_1200) >> rate_idx;

    // request decode
    wire go_xmit = fitted_r && xmit_req && (xmit_sel != 2'h3);
    wire go_print = fitted_r && (print_req || print_lvl_r);
    wire [2:0] xmit_mask = 3'(1) << xmit_sel;
    wire [2:0] print_mask = {print_content_select[1],
                             print_content_select[1],
                             print_content_select[0]};

    srf_state_t state_r;
    srf_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [3:0] idx_r;
    logic [3:0] idx_nxt;
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;
    logic [2:0] mask_r;
    logic [2:0] mask_nxt;
    logic is_print_r;
    logic accept;
    logic [VAL_W-1:0] tmr_cap_r;
    logic [VAL_W-1:0] p1_cap_r;
    logic [VAL_W-1:0] p2_cap_r;

    wire [VAL_W-1:0] cur_val = (sel_r == VAL_TIMER) ? tmr_cap_r :
                               ((sel_r == VAL_P1) ? p1_cap_r : p2_cap_r);
    wire [1:0] next_sel = first_sel(mask_r);
    wire [VAL_W-1:0] next_val = (next_sel == VAL_TIMER) ? tmr_cap_r :
                         ((next_sel == VAL_P1) ? p1_cap_r : p2_cap_r);
    wire [3:0] start_idx = short_report_select ?
        POS_DIG0 + {1'b0, first_sig(next_val)} : POS_ADDR_HI;
    wire [7:0] q_data = char_at(idx_r, cur_val,
                                unit_address_setting, sel_r);
    wire q_valid = (state_r == ST_EMIT);
    wire q_ready;
    wire tx_valid;
    wire [7:0] tx_data;
    wire tx_ready;
    wire tx_busy;
    wire line_quiet = !tx_valid && !tx_busy;
    wire cnt_zero = (cnt_r == '0);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        sel_nxt = sel_r;
        mask_nxt = mask_r;
        accept = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (go_xmit || go_print) begin
                    accept = 1'b1;
                    mask_nxt = go_xmit ? xmit_mask : print_mask;
                    cnt_nxt = CNT_W'(HOLD_CYCLES - 1);
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_zero) begin
                    sel_nxt = next_sel;
                    idx_nxt = start_idx;
                    state_nxt = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (q_ready) begin
                    idx_nxt = idx_r + 1'b1;
                    if (idx_r == POS_LF) begin
                        mask_nxt = mask_r & ~(3'(1) << sel_r);
                        state_nxt = ST_DRAIN;
                    end
                end
            end
            ST_DRAIN: begin
                if (line_quiet) begin
                    if (mask_r == MASK_NONE) begin
                        state_nxt = ST_IDLE;
                    end else if (is_print_r && !short_report_select) begin
                        cnt_nxt = CNT_W'(GAP_CYCLES - 1);
                        state_nxt = ST_GAP;
                    end else begin
                        sel_nxt = next_sel;
                        idx_nxt = start_idx;
                        state_nxt = ST_EMIT;
                    end
                end
            end
            ST_GAP: begin
                cnt_nxt = cnt_r - 1'b1;
                if (cnt_zero) begin
                    sel_nxt = next_sel;
                    idx_nxt = start_idx;
                    state_nxt = ST_EMIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            idx_r <= POS_ADDR_HI;
            sel_r <= VAL_TIMER;
            mask_r <= MASK_NONE;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            sel_r <= sel_nxt;
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            is_print_r <= 1'b0;
            tmr_cap_r <= '0;
            p1_cap_r <= '0;
            p2_cap_r <= '0;
        end else if (accept) begin
            is_print_r <= !go_xmit;
            tmr_cap_r <= timer_value;
            p1_cap_r <= preset1_value;
            p2_cap_r <= preset2_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_ack <= 1'b0;
            timer_reset <= 1'b0;
            busy <= 1'b0;
            tx_drive_en <= 1'b0;
        end else begin
            req_ack <= accept;
            // value is captured on this same edge
            timer_reset <= accept && !go_xmit &&
                           reset_after_print_select &&
                           print_mask[0];
            busy <= (state_nxt != ST_IDLE);
            tx_drive_en <= (state_nxt != ST_IDLE) &&
                           (state_nxt != ST_HOLD);
        end
    end

    srf_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .clk(clk),
        .rst_n(rst_n),
        .s_valid(q_valid),
        .s_data(q_data),
        .s_ready(q_ready),
        .m_valid(tx_valid),
        .m_data(tx_data),
        .m_ready(tx_ready)
    );

    srf_uart_tx #(
        .DIV_W(DIV_W)
    ) u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .bit_div(bit_div),
        .parity(par_kind),
        .s_valid(tx_valid),
        .s_data(tx_data),
        .s_ready(tx_ready),
        .line_o(tx_line),
        .busy_o(tx_busy)
    );
endmodule

/* src/srf_uart_tx.sv */
`timescale 1ns/10ps
module srf_uart_tx
    import srf_pkg::*;
#(
    parameter int DIV_W = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [DIV_W-1:0] bit_div,
    input wire srf_parity_t parity,
    input wire logic s_valid,
    input wire logic [CHAR_W-1:0] s_data,
    output logic s_ready,
    output logic line_o,
    output logic busy_o
);
    logic [FRAME_BITS-2:0] shift_r;
    logic [3:0] left_r;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] cnt_r;
    logic [FRAME_BITS-1:0] frame;
    wire par_bit = (parity == PAR_ODD) ? ~^s_data[6:0] : ^s_data[6:0];
    wire take = s_valid && !busy_o;
    wire tick = (cnt_r == '0);

    // start, data lsb first, optional parity, one stop; always ten bits
    assign frame = (parity == PAR_NONE) ?
        {1'b1, s_data, 1'b0} :
        {1'b1, par_bit, s_data[6:0], 1'b0};
    assign s_ready = !busy_o;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            line_o <= 1'b1;
            busy_o <= 1'b0;
            shift_r <= '1;
            left_r <= '0;
            div_r <= '0;
            cnt_r <= '0;
        end else if (take) begin
            line_o <= frame[0];
            shift_r <= frame[FRAME_BITS-1:1];
            left_r <= 4'(FRAME_BITS - 1);
            div_r <= bit_div;
            cnt_r <= bit_div - 1'b1;
            busy_o <= 1'b1;
        end else if (busy_o && tick) begin
            if (left_r == '0) begin
                busy_o <= 1'b0;
            end else begin
                line_o <= shift_r[0];
                shift_r <= {1'b1, shift_r[FRAME_BITS-2:1]};
                left_r <= left_r - 1'b1;
                cnt_r <= div_r - 1'b1;
            end
        end else if (busy_o) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule
